/* File: serd_read_path.sv */
`timescale 1ns/1ps
`default_nettype none
module serd_read_path #(
   parameter int MEM_WORDS = serd_pkg::MEM_DEPTH,
   parameter int PAGE_SIZE = serd_pkg::PAGE_BYTES
)(
   input  wire logic                             mclk_in,
   input  wire logic                             rstn_in,
   input  wire logic                             scl_clk_in,
   input  wire logic                             sda_in,
   output logic                                  sda_out,
   output logic                                  sda_oe_out,
   input  wire logic                             strap_addr_bit2_in,
   input  wire logic                             strap_addr_bit1_in,
   input  wire logic                             strap_addr_bit0_in,
   input  wire logic [serd_pkg::SERIAL_BITS-1:0] serial_number_in,
   output logic [7:0]                            addr_ptr_out,
   output logic                                  busy_out
);
   import serd_pkg::*;

   localparam logic [7:0] ADDR_MASK = 8'(MEM_WORDS - 1);
   localparam logic [7:0] PAGE_MASK = 8'(PAGE_SIZE - 1);

   // increments only the bits under the mask, the rest stay put
   function automatic logic [7:0] wrap_inc(input logic [7:0] p, input logic [7:0] m);
      wrap_inc = (p & ~m) | ((p + 8'h01) & m);
   endfunction

   logic           rst_s1_reg;
   logic           rst_n_reg;
   logic           scl_s1_reg;
   logic           scl_s2_reg;
   logic           scl_s3_reg;
   logic           sda_s1_reg;
   logic           sda_s2_reg;
   logic           sda_s3_reg;
   logic [2:0]     strap_s1_reg;
   logic [2:0]     strap_s2_reg;
   logic [7:0]     link_shift_reg;
   serd_state_type state_reg;
   serd_state_type state_next;
   logic [3:0]     bit_cnt_reg;
   logic [3:0]     bit_cnt_next;
   logic [7:0]     ptr_reg;
   logic [7:0]     ptr_next;
   logic [7:0]     tx_reg;
   logic [7:0]     tx_next;
   logic           sda_oe_reg;
   logic           sda_oe_next;
   logic           rd_reg;
   logic           rd_next;
   logic           serial_reg;
   logic           serial_next;
   logic           busy_reg;
   logic           sda_out_reg;
   logic [7:0]     mem [0:MEM_WORDS-1];

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   // bus pins reach the engine through three flops and straps through two; data bits also arrive via the link shifter
   always_ff @(posedge mclk_in or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         scl_s1_reg   <= 1'b1;
         scl_s2_reg   <= 1'b1;
         scl_s3_reg   <= 1'b1;
         sda_s1_reg   <= 1'b1;
         sda_s2_reg   <= 1'b1;
         sda_s3_reg   <= 1'b1;
         strap_s1_reg <= 3'h0;
         strap_s2_reg <= 3'h0;
      end
      else
      begin
         scl_s1_reg   <= scl_clk_in;
         scl_s2_reg   <= scl_s1_reg;
         scl_s3_reg   <= scl_s2_reg;
         sda_s1_reg   <= sda_in;
         sda_s2_reg   <= sda_s1_reg;
         sda_s3_reg   <= sda_s2_reg;
         strap_s1_reg <= {strap_addr_bit2_in, strap_addr_bit1_in, strap_addr_bit0_in};
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // link side: bits are taken on the bus clock itself; the word is read by
   // the engine at the synchronised falling edge after the eighth bit, while it is stable
   always_ff @(posedge scl_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         link_shift_reg <= 8'h00;
      else
         link_shift_reg <= {link_shift_reg[6:0], sda_in};
   end

   // start/stop need scl high in both stages; data moved while scl is low never fakes one
   wire logic       scl_rise    = scl_s2_reg & ~scl_s3_reg;
   wire logic       scl_fall    = ~scl_s2_reg & scl_s3_reg;
   wire logic       start_det   = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
   wire logic       stop_det    = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
   wire logic [7:0] rx_word     = link_shift_reg;
   wire logic       type_ok     = rx_word[7:4] == TYPE_ARRAY || rx_word[7:4] == TYPE_SERIAL;
   wire logic       addr_match  = type_ok && rx_word[3:1] == strap_s2_reg;
   wire logic       at_ack_fall = scl_fall && bit_cnt_reg == CNT_ACK;
   wire logic       at_end_fall = scl_fall && bit_cnt_reg == CNT_END;
   wire logic       tx_shift    = scl_fall && bit_cnt_reg != CNT_ZERO && bit_cnt_reg < CNT_ACK;
   // the controller's ack is taken on the rise, where its level has settled
   wire logic       ctl_nack    = scl_rise && bit_cnt_reg == CNT_ACK && sda_s2_reg;
   wire logic       counting    = state_reg != ST_IDLE && state_reg != ST_WAIT;
   wire logic [SERIAL_BITS-1:0] sn_shifted = serial_number_in << {ptr_reg[3:0], 3'h0};
   wire logic [7:0] sn_byte     = sn_shifted[SERIAL_BITS-1 -: 8];
   wire logic       serial_ok   = ptr_reg[7:6] == SERIAL_PREFIX;
   wire logic [7:0] arr_byte    = mem[ptr_reg & ADDR_MASK];
   wire logic [7:0] rd_byte     = serial_reg ? (serial_ok ? sn_byte : UNDEF_BYTE) : arr_byte;
   wire logic       rd_msb      = rd_byte[7];
   wire logic       load_byte   = at_end_fall && (state_reg == ST_RDATA || (state_reg == ST_ADDR && rd_reg));
   wire logic       mem_we      = at_ack_fall && state_reg == ST_WDATA && !serial_reg;
   wire logic [7:0] rd_inc      = serial_reg ? wrap_inc(ptr_reg, SERIAL_MASK)
                                             : wrap_inc(ptr_reg & ADDR_MASK, ADDR_MASK);

   always_comb
   begin
      state_next   = state_reg;
      bit_cnt_next = bit_cnt_reg;
      ptr_next     = ptr_reg;
      tx_next      = tx_reg;
      sda_oe_next  = sda_oe_reg;
      rd_next      = rd_reg;
      serial_next  = serial_reg;
      if (scl_rise && counting)
         bit_cnt_next = bit_cnt_reg + CNT_ONE;
      unique case (state_reg)
         ST_ADDR:
         begin
            if (at_ack_fall && addr_match)
            begin
               sda_oe_next = 1'b1;
               rd_next     = rx_word[0];
               serial_next = rx_word[7:4] == TYPE_SERIAL;
            end
            else if (at_ack_fall)
               state_next = ST_IDLE;
            else if (at_end_fall)
            begin
               bit_cnt_next = CNT_ZERO;
               if (!rd_reg)
               begin
                  sda_oe_next = 1'b0;
                  state_next  = ST_WORD;
               end
            end
         end
         ST_WORD:
         begin
            if (at_ack_fall)
            begin
               sda_oe_next = 1'b1;
               ptr_next    = rx_word;
            end
            else if (at_end_fall)
            begin
               sda_oe_next  = 1'b0;
               bit_cnt_next = CNT_ZERO;
               state_next   = ST_WDATA;
            end
         end
         ST_WDATA:
         begin
            if (at_ack_fall)
            begin
               sda_oe_next = 1'b1;
               if (!serial_reg)
                  ptr_next = wrap_inc(ptr_reg, PAGE_MASK);
            end
            else if (at_end_fall)
            begin
               sda_oe_next  = 1'b0;
               bit_cnt_next = CNT_ZERO;
            end
         end
         ST_RDATA:
         begin
            if (tx_shift)
            begin
               sda_oe_next = ~tx_reg[7];
               tx_next     = {tx_reg[6:0], 1'b0};
            end
            else if (at_ack_fall)
               sda_oe_next = 1'b0;
            else if (ctl_nack)
               state_next = ST_WAIT;
         end
         ST_IDLE, ST_WAIT: ;
      endcase
      // the pointer moves as each byte is fetched, so it always names
      // the location after the last one sent
      if (load_byte)
      begin
         sda_oe_next  = ~rd_msb;
         tx_next      = {rd_byte[6:0], 1'b0};
         ptr_next     = rd_inc;
         bit_cnt_next = CNT_ZERO;
         state_next   = ST_RDATA;
      end
      if (start_det)
      begin
         state_next   = ST_ADDR;
         bit_cnt_next = CNT_ZERO;
         sda_oe_next  = 1'b0;
      end
      if (stop_det)
      begin
         state_next   = ST_IDLE;
         bit_cnt_next = CNT_ZERO;
         sda_oe_next  = 1'b0;
      end
   end

   // pointer is only cleared by reset, standing in for power-up
   always_ff @(posedge mclk_in or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= CNT_ZERO;
         ptr_reg     <= PTR_ZERO;
         tx_reg      <= PTR_ZERO;
         sda_oe_reg  <= 1'b0;
         rd_reg      <= 1'b0;
         serial_reg  <= 1'b0;
         busy_reg    <= 1'b0;
         sda_out_reg <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         ptr_reg     <= ptr_next;
         tx_reg      <= tx_next;
         sda_oe_reg  <= sda_oe_next;
         rd_reg      <= rd_next;
         serial_reg  <= serial_next;
         busy_reg    <= state_next != ST_IDLE;
         sda_out_reg <= 1'b0;
      end
   end

   // array content is nonvolatile, so it carries no reset
   always_ff @(posedge mclk_in)
   begin
      if (mem_we)
         mem[ptr_reg & ADDR_MASK] <= rx_word;
   end

   assign sda_out      = sda_out_reg;
   assign sda_oe_out   = sda_oe_reg;
   assign addr_ptr_out = ptr_reg;
   assign busy_out     = busy_reg;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_reg);

   a_strap_mismatch_idle: assert property (
      state_reg == ST_ADDR && at_ack_fall && !addr_match |=> state_reg == ST_IDLE && !sda_oe_reg)
      else $error("mismatched address not dropped");
   a_addr_ack_drive: assert property (
      state_reg == ST_ADDR && at_ack_fall && addr_match |=> sda_oe_reg && state_reg == ST_ADDR)
      else $error("matching address not acknowledged");
   a_stop_release_line: assert property (
      stop_det |=> state_reg == ST_IDLE && !sda_oe_reg ##1 !sda_oe_reg)
      else $error("data line held after stop");
   a_word_load_ptr: assert property (
      state_reg == ST_WORD && at_ack_fall |=> ptr_reg == $past(rx_word) && sda_oe_reg)
      else $error("word address not loaded");
   a_msb_first_out: assert property (
      load_byte |=> state_reg == ST_RDATA && sda_oe_reg == !$past(rd_msb))
      else $error("first data bit not msb");
   a_array_read_wrap: assert property (
      load_byte && !serial_reg && (ptr_reg & ADDR_MASK) == ADDR_MASK |=> ptr_reg == PTR_ZERO)
      else $error("array read did not wrap to zero");
   a_serial_wrap_ptr: assert property (
      load_byte && serial_reg && (ptr_reg & SERIAL_MASK) == SERIAL_MASK
      |=> (ptr_reg & SERIAL_MASK) == PTR_ZERO
          && ((ptr_reg ^ $past(ptr_reg)) & ~SERIAL_MASK) == PTR_ZERO)
      else $error("serial pointer did not wrap in block");
   a_page_write_wrap: assert property (
      mem_we && (ptr_reg & PAGE_MASK) == PAGE_MASK
      |=> (ptr_reg & PAGE_MASK) == PTR_ZERO
          && ((ptr_reg ^ $past(ptr_reg)) & ~PAGE_MASK) == PTR_ZERO)
      else $error("write pointer left its page");
   a_serial_write_ro: assert property (
      state_reg == ST_WDATA && serial_reg && at_ack_fall |=> $stable(ptr_reg) && sda_oe_reg)
      else $error("serial block write moved pointer");
   a_ptr_idle_hold: assert property (
      state_reg == ST_IDLE && !start_det |=> $stable(ptr_reg))
      else $error("pointer changed between transactions");
   a_nack_ends_read: assert property (
      state_reg == ST_RDATA && ctl_nack && !stop_det |=> state_reg == ST_WAIT && !sda_oe_reg)
      else $error("read continued after missing ack");

   // per-bit behaviour that the bench only sees as whole bytes
   a_read_ptr_step: assert property (
      load_byte && !serial_reg && (ptr_reg & ADDR_MASK) != ADDR_MASK
      |=> (ptr_reg & ADDR_MASK) == ($past(ptr_reg & ADDR_MASK) + 8'h01))
      else $error("read pointer did not step by one");
   a_data_bit_order: assert property (
      state_reg == ST_RDATA && tx_shift |=> sda_oe_reg == !$past(tx_reg[7]))
      else $error("data bit out of order");
   a_read_ack_release: assert property (
      state_reg == ST_RDATA && at_ack_fall |=> !sda_oe_reg)
      else $error("data line not released for controller ack");
   a_write_ack_drive: assert property (
      state_reg == ST_WDATA && at_ack_fall |=> sda_oe_reg)
      else $error("data byte not acknowledged");
   a_serial_upper_hold: assert property (
      load_byte && serial_reg |=> ((ptr_reg ^ $past(ptr_reg)) & ~SERIAL_MASK) == PTR_ZERO)
      else $error("serial read left its block");
   a_nack_line_quiet: assert property (
      state_reg == ST_WAIT && !start_det |=> !sda_oe_reg)
      else $error("data line driven after missing ack");

   c_random_read: cover property (state_reg == ST_WORD ##[1:1000] load_byte);
   c_seq_read: cover property (state_reg == ST_RDATA && load_byte);
   c_serial_read: cover property (load_byte && serial_reg && serial_ok);
   c_read_nack: cover property (state_reg == ST_RDATA && ctl_nack);
   c_page_wrap: cover property (mem_we && (ptr_reg & PAGE_MASK) == PAGE_MASK);
endmodule // serd_read_path
`default_nettype wire

/* File: serd_pkg.sv */
// Functional notes
// - a read opens like a write but with the direction bit set
// - pointer holds last accessed location plus one
// - pointer survives between transactions while powered
// - array read past the last byte wraps to byte zero
// - write increment wraps within the current page
// - after a read address ack, send pointed byte msb first
// - dummy write acks both bytes and loads pointer, memory untouched
// - each controller ack advances pointer and sends next byte
// - sequential read wraps from top of array to zero
// - no ack then stop ends a read; data line released
// - address byte: type code, three strap bits, direction bit
// - one pointer shared by array and serial block
// - serial access needs word address prefix 10, else undefined data
// - serial pointer wraps after sixteenth byte to the first
// - serial read ends with withheld ack and stop
// - ack address only when strap bits match strap inputs
// - ack each received byte by pulling data low in ninth clock
// - serial block is read only
package serd_pkg;
   localparam logic [3:0] TYPE_ARRAY    = 4'ha;
   localparam logic [3:0] TYPE_SERIAL   = 4'hb;
   localparam logic [1:0] SERIAL_PREFIX = 2'h2;
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_ONE       = 4'h1;
   localparam logic [3:0] CNT_ACK       = 4'h8;
   localparam logic [3:0] CNT_END       = 4'h9;
   localparam logic [7:0] UNDEF_BYTE    = 8'hff;
   localparam logic [7:0] PTR_ZERO      = 8'h00;
   localparam logic [7:0] SERIAL_MASK   = 8'h0f;
   localparam int         MEM_DEPTH     = 256;
   localparam int         PAGE_BYTES    = 8;
   localparam int         SERIAL_BITS   = 128;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WORD, ST_WDATA, ST_RDATA, ST_WAIT}
      serd_state_type;
endpackage

/* File: serd_bus_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module serd_bus_ctrl (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // link timing is built from 12 ns ticks; scl stands high between frames
   localparam realtime TICK = 12.0;

   initial
   begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic wait_ticks(input int n);
      #(TICK * n);
   endtask

   // data moves two ticks after the fall so the device never sees it near an edge
   task automatic clock_bit(input logic tx, output logic rx);
      wait_ticks(2);
      sda_low_out = ~tx;
      wait_ticks(2);
      scl_out = 1'b1;
      wait_ticks(2);
      rx = sda_in;
      wait_ticks(2);
      scl_out = 1'b0;
   endtask

   task automatic start_cond();
      wait_ticks(2);
      sda_low_out = 1'b0;
      wait_ticks(2);
      scl_out = 1'b1;
      wait_ticks(2);
      sda_low_out = 1'b1;
      wait_ticks(2);
      scl_out = 1'b0;
   endtask

   task automatic stop_cond();
      wait_ticks(2);
      sda_low_out = 1'b1;
      wait_ticks(2);
      scl_out = 1'b1;
      wait_ticks(2);
      sda_low_out = 1'b0;
      wait_ticks(4);
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         clock_bit(d[i], r);
      clock_bit(1'b1, r);
      ack = ~r;
   endtask

   // ack high pulls the line low and keeps a sequential read going, ack low ends it
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         clock_bit(1'b1, d[i]);
      clock_bit(~ack, r);
   endtask
endmodule // serd_bus_ctrl
`default_nettype wire

/* File: tb_serial_eeprom_read_path.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_read_path;
   import serd_pkg::*;
   typedef struct packed {logic [3:0] dtype; logic [3:0] rtype; logic [7:0] addr; logic [7:0] cnt;}
      serd_row_type;
   logic         mclk_in = 1'b0;
   logic         rstn_in = 1'b0;
   logic [2:0]   straps  = 3'h5;
   logic         scl;
   logic         ctrl_low;
   wire          sda_wire;
   logic         sda_out;
   logic         sda_oe;
   logic [7:0]   ptr;
   logic         busy;
   logic [127:0] serial = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
   logic [7:0]   shadow [256];
   logic [7:0]   exp_ptr = 8'h00;
   int           mismatches = 0;
   int           total_checks = 0;
   int           cycles = 0;
   serd_row_type rows [9] = '{
      '{4'ha, 4'ha, 8'hfc, 8'h01}, '{4'h0, 4'ha, 8'h00, 8'h02}, '{4'ha, 4'ha, 8'hfe, 8'h04},
      '{4'h0, 4'hb, 8'h00, 8'h01}, '{4'hb, 4'ha, 8'h05, 8'h01}, '{4'hb, 4'hb, 8'h80, 8'h12},
      '{4'hb, 4'hb, 8'h8e, 8'h03}, '{4'hb, 4'hb, 8'h45, 8'h01}, '{4'ha, 4'hb, 8'h93, 8'h02}};

   // pull-up on the data line; either party may only pull it low
   assign sda_wire = ~(ctrl_low | sda_oe);

   serd_read_path u_dut (
      .mclk_in            (mclk_in),
      .rstn_in            (rstn_in),
      .scl_clk_in         (scl),
      .sda_in             (sda_wire),
      .sda_out            (sda_out),
      .sda_oe_out         (sda_oe),
      .strap_addr_bit2_in (straps[2]),
      .strap_addr_bit1_in (straps[1]),
      .strap_addr_bit0_in (straps[0]),
      .serial_number_in   (serial),
      .addr_ptr_out       (ptr),
      .busy_out           (busy)
   );
   serd_bus_ctrl u_ctrl (
      .sda_in      (sda_wire),
      .scl_out     (scl),
      .sda_low_out (ctrl_low)
   );

   always #2.5 mclk_in = ~mclk_in;

   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         mismatches++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] exp_byte(input logic [7:0] p, input logic ser);
      if (!ser)
         return shadow[p];
      return (p[7:6] == SERIAL_PREFIX) ? serial[127 - 8 * p[3:0] -: 8] : UNDEF_BYTE;
   endfunction

   task automatic set_word(input logic [3:0] t, input logic [7:0] a);
      logic ack;
      u_ctrl.start_cond();
      u_ctrl.put_byte({t, straps, 1'b0}, ack);
      check("write addr ack", ack, 8'h01);
      u_ctrl.put_byte(a, ack);
      check("word addr ack", ack, 8'h01);
      exp_ptr = a;
   endtask

   task automatic write_page(input logic [7:0] a);
      logic       ack;
      logic [7:0] d;
      set_word(TYPE_ARRAY, a);
      for (int i = 0; i < 8; i++)
      begin
         d = a + 8'h40 + 8'(i);
         u_ctrl.put_byte(d, ack);
         shadow[exp_ptr] = d;
         exp_ptr = {exp_ptr[7:3], exp_ptr[2:0] + 3'h1};
      end
      u_ctrl.stop_cond();
      check("pointer after write", ptr, exp_ptr);
   endtask

   task automatic run_row(input serd_row_type r);
      logic       ack;
      logic [7:0] d;
      logic       ser;
      ser = (r.rtype == TYPE_SERIAL);
      if (r.dtype != 4'h0)
         set_word(r.dtype, r.addr);
      u_ctrl.start_cond();
      u_ctrl.put_byte({r.rtype, straps, 1'b1}, ack);
      check("read addr ack", ack, 8'h01);
      check("busy in read", busy, 8'h01);
      for (int i = 0; i < r.cnt; i++)
      begin
         u_ctrl.get_byte(i != r.cnt - 1, d);
         check("read data", d, exp_byte(exp_ptr, ser));
         exp_ptr = ser ? {exp_ptr[7:4], exp_ptr[3:0] + 4'h1} : exp_ptr + 8'h01;
      end
      u_ctrl.stop_cond();
      check("pointer", ptr, exp_ptr);
      check("data line released", sda_oe, 8'h00);
      check("busy after stop", busy, 8'h00);
      check("drive value", sda_out, 8'h00);
   endtask

   initial
   begin
      logic ack;
      repeat (4) @(posedge mclk_in);
      check("reset pointer", ptr, 8'h00);
      check("reset drive", sda_oe, 8'h00);
      check("reset busy", busy, 8'h00);
      repeat (2) @(posedge mclk_in);
      #1 rstn_in = 1'b1;
      repeat (10) @(posedge mclk_in);
      write_page(8'hfc);
      write_page(8'h00);
      foreach (rows[k])
         run_row(rows[k]);
      // serial content must survive a write-type access
      set_word(TYPE_SERIAL, 8'h80);
      u_ctrl.put_byte(8'h5a, ack);
      check("serial data ack", ack, 8'h01);
      u_ctrl.stop_cond();
      run_row(serd_row_type'{4'h0, TYPE_SERIAL, 8'h00, 8'h01});
      @(posedge mclk_in);
      #1 straps = 3'h2;
      repeat (5) @(posedge mclk_in);
      for (int k = 0; k < 9; k++)
      begin
         u_ctrl.start_cond();
         u_ctrl.put_byte({(k == 8) ? 4'h9 : TYPE_ARRAY, 3'(k), 1'b0}, ack);
         check("strap ack", ack, 8'((k < 8) && (3'(k) == straps)));
         u_ctrl.stop_cond();
      end
      run_row(serd_row_type'{TYPE_ARRAY, TYPE_ARRAY, 8'hff, 8'h02});
      conclude();
   end
endmodule // tb_serial_eeprom_read_path
`default_nettype wire
